// file: src/fcm_pkg.sv
// Package holding the register map, field positions and constants of the clock mode block.
package fcm_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TRIM = 8'h08;
	localparam logic [7:0] ADDR_IRQCTL = 8'h0c;
	localparam int STS_LOST = 7;
	localparam int STS_LOCKED = 6;
	localparam int STS_REFST = 4;
	localparam int STS_MODE_LO = 2;
	localparam int CTL_CLKSEL_LO = 6;
	localparam int CTL_REFINT = 2;
	localparam int CTL_DIV_LO = 3;
	localparam int CTL_IROUT = 1;
	localparam int CTL_IRSTOP = 0;
	localparam int CTL_LPDIS = 8;
	localparam int IRQ_LOST_LOCK_IRQ_ENABLE = 7;
	localparam int IRQ_CME = 5;
	localparam logic [1:0] CLK_FLL = 2'h0;
	localparam logic [1:0] CLK_INT = 2'h1;
	localparam logic [1:0] CLK_EXT = 2'h2;
	localparam logic [8:0] CTRL_RESET = 9'h004;
	localparam logic [7:0] TRIM_RESET = 8'h80;
	localparam int FLL_MULT = 1280;
	localparam int LOCK_TOL_MIN_PERMILLE = 47;
	localparam int LOCK_TOL_MAX_PERMILLE = 60;
	localparam int SYNC_STAGES = 2;
	typedef struct packed {
		logic [1:0] clock_source_select;
		logic [2:0] ref_divider;
		logic ref_select_internal;
		logic internal_ref_out_enable;
		logic internal_ref_stop_enable;
	} fcm_ctrl_t;
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_ACQ = 4'h2,
		ST_LOCK = 4'h4,
		ST_LOST = 4'h8
	} fcm_lock_t;
endpackage

// file: src/fcm_sync.sv
// Two-stage level synchroniser for a bus of status bits.
module fcm_sync #(
	parameter int W = 3
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end
	assign q = q_ff;
endmodule

// file: src/fcm_top.sv
// Clock mode selection, lock tracking and status register of the loop clock generator.
// How it works
// - Lost-lock flag sets when lock was held and loop leaves tolerance band.
// - Lost-lock flag clears on reset or write one; write zero ignored.
// - Interrupt request asserts while lost-lock flag set and its enable set.
// - Status bit 6 shows locked; no lock detection while loop disabled.
// - Reference select, divider, or internal-mode trim change clears locked status.
// - Stop entry clears locked status until lock reacquired after stop.
// - Status bit 5 and unused bits read zero and are read-only.
// - Status bit 4 shows reference in use after synchronisation.
// - Status bits 3-2 show active output source after synchronisation.
// - Reset selects internal-reference engaged mode.
// - Engaged and non-low-power bypass modes lock loop at 1280 times reference.
// - External engaged mode outputs loop clock; software keeps divided ref in range.
// - Internal bypass outputs internal reference while loop stays locked to it.
// - Internal bypass low power outputs internal reference, loop disabled.
// - External bypass outputs external reference while loop stays locked.
// - External bypass low power outputs external reference, loop off, ref on.
// - Stop holds all clocks static except internal ref when both enables set.
// - Stop entry returns oscillator to reset value and forces reacquisition.
// - Low-power disable powers loop down in bypass unless debug active.
// - An unavailable newly chosen clock leaves the previous clock selected.
// - Clock monitor enable requests reset on external clock loss.
//
// Implementation choice: the Wishbone register port.
module fcm_top #(
	parameter int ACQ_CYCLES = 64
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic stop_req,
	input wire logic debug_active,
	input wire logic int_ref_ready,
	input wire logic ext_ref_ready,
	input wire logic ext_clock_lost,
	input wire logic fll_in_band,
	input wire logic fll_out_of_tol,
	output logic [1:0] out_clock_source,
	output logic fll_enable,
	output logic ext_ref_enable,
	output logic int_ref_enable,
	output logic int_ref_clock_gate,
	output logic out_clock_gate,
	output logic osc_reset_freq,
	output logic [15:0] fll_multiplier,
	output logic lost_lock_irq,
	output logic reset_req
);
	fcm_pkg::fcm_ctrl_t ctrl_ff;
	logic lp_dis_ff;
	logic [7:0] trim_ff;
	logic lost_lock_irq_enable_ff;
	logic cme_ff;
	logic lost_ff;
	logic [1:0] src_ff;
	logic ref_int_ff;
	logic stop_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	fcm_pkg::fcm_lock_t lock_ff;
	fcm_pkg::fcm_lock_t nxt_lock;
	logic [15:0] acq_cnt_ff;
	logic [15:0] nxt_acq_cnt;
	logic [2:0] sync_q;
	wire req = wb_cyc_i && wb_stb_i;
	wire hit_ctrl = wb_adr_i == fcm_pkg::ADDR_CTRL;
	wire hit_sts = wb_adr_i == fcm_pkg::ADDR_STATUS;
	wire hit_trim = wb_adr_i == fcm_pkg::ADDR_TRIM;
	wire hit_irq = wb_adr_i == fcm_pkg::ADDR_IRQCTL;
	wire hit_any = hit_ctrl || hit_sts || hit_trim || hit_irq;
	// Access completes in the first cycle after request; ack drops next cycle.
	wire take = req && !ack_ff;
	wire wr_ok = take && wb_we_i && hit_any;
	wire wr_ctrl_lo = wr_ok && hit_ctrl && wb_sel_i[0];
	wire wr_ctrl_hi = wr_ok && hit_ctrl && wb_sel_i[1];
	wire wr_trim = wr_ok && hit_trim && wb_sel_i[0];
	wire wr_irq = wr_ok && hit_irq && wb_sel_i[0];
	wire wr_sts = wr_ok && hit_sts && wb_sel_i[0];
	wire [1:0] clksel = ctrl_ff.clock_source_select;
	wire bypass = clksel != fcm_pkg::CLK_FLL;
	// Low-power disable only takes the loop down in bypass, and debug vetoes it.
	wire fll_pd = bypass && lp_dis_ff && !debug_active;
	wire fll_on = !fll_pd && !stop_ff;
	// A write that changes reference, divider or, internally, trim drops lock.
	wire [8:0] ctl_new = {wb_dat_i[fcm_pkg::CTL_CLKSEL_LO +: 2],
		wb_dat_i[fcm_pkg::CTL_DIV_LO +: 3], wb_dat_i[fcm_pkg::CTL_REFINT],
		wb_dat_i[fcm_pkg::CTL_IROUT], wb_dat_i[fcm_pkg::CTL_IRSTOP],
		1'b0};
	wire ref_chg = wr_ctrl_lo && (ctl_new[6:3] !=
		{ctrl_ff.ref_divider, ctrl_ff.ref_select_internal});
	wire trim_chg = wr_trim && ctrl_ff.ref_select_internal &&
		clksel != fcm_pkg::CLK_EXT && wb_dat_i[7:0] != trim_ff;
	wire stop_entry = stop_req && !stop_ff;
	wire relock = ref_chg || trim_chg || stop_entry;
	wire lose = lock_ff == fcm_pkg::ST_LOCK && fll_out_of_tol && !relock;
	wire lost_clr = wr_sts && wb_dat_i[fcm_pkg::STS_LOST] && lost_ff;
	// Wanted source; an unavailable target keeps the old one.
	wire want_ok = (clksel == fcm_pkg::CLK_INT) ? int_ref_ready :
		(clksel == fcm_pkg::CLK_EXT) ? ext_ref_ready :
		(clksel == fcm_pkg::CLK_FLL);
	wire ref_ok = ctrl_ff.ref_select_internal ? int_ref_ready :
		ext_ref_ready;
	wire [7:0] status = {lost_ff, lock_ff == fcm_pkg::ST_LOCK, 1'b0,
		sync_q[2], sync_q[1:0], 2'h0};
	wire [31:0] rd_mux = hit_ctrl ? {23'h0, lp_dis_ff, ctrl_ff.clock_source_select,
		ctrl_ff.ref_divider, ctrl_ff.ref_select_internal,
		ctrl_ff.internal_ref_out_enable, ctrl_ff.internal_ref_stop_enable} :
		hit_sts ? {24'h0, status} :
		hit_trim ? {24'h0, trim_ff} :
		hit_irq ? {24'h0, lost_lock_irq_enable_ff, 1'b0, cme_ff, 5'h0} : 32'h0;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end
		else
		begin
			ack_ff <= take;
			rdat_ff <= take ? rd_mux : rdat_ff;
		end
	end
	assign wb_ack_o = ack_ff && hit_any && req;
	assign wb_err_o = ack_ff && !hit_any && req;
	assign wb_dat_o = rdat_ff;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_ff <= fcm_pkg::fcm_ctrl_t'(fcm_pkg::CTRL_RESET[7:0]);
			lp_dis_ff <= fcm_pkg::CTRL_RESET[8];
			trim_ff <= fcm_pkg::TRIM_RESET;
			lost_lock_irq_enable_ff <= 1'b0;
			cme_ff <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_lo)
				ctrl_ff <= fcm_pkg::fcm_ctrl_t'(ctl_new[8:1]);
			if (wr_ctrl_hi)
				lp_dis_ff <= wb_dat_i[fcm_pkg::CTL_LPDIS];
			if (wr_trim)
				trim_ff <= wb_dat_i[7:0];
			if (wr_irq)
			begin
				lost_lock_irq_enable_ff <= wb_dat_i[fcm_pkg::IRQ_LOST_LOCK_IRQ_ENABLE];
				cme_ff <= wb_dat_i[fcm_pkg::IRQ_CME];
			end
		end
	end

	// Set wins over a simultaneous software clear.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			lost_ff <= 1'b0;
		else if (lose)
			lost_ff <= 1'b1;
		else if (lost_clr)
			lost_ff <= 1'b0;
	end
	assign lost_lock_irq = lost_ff && lost_lock_irq_enable_ff;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stop_ff <= 1'b0;
			src_ff <= fcm_pkg::CLK_FLL;
			ref_int_ff <= 1'b1;
		end
		else
		begin
			stop_ff <= stop_req;
			if (want_ok)
				src_ff <= clksel;
			if (ref_ok)
				ref_int_ff <= ctrl_ff.ref_select_internal;
		end
	end

	// Acquisition counter stands in for the loop settling after any restart.
	always_comb
	begin
		nxt_lock = lock_ff;
		nxt_acq_cnt = acq_cnt_ff;
		case (lock_ff)
			fcm_pkg::ST_OFF:
			begin
				nxt_acq_cnt = 16'h0;
				if (fll_on)
					nxt_lock = fcm_pkg::ST_ACQ;
			end
			fcm_pkg::ST_ACQ:
			begin
				nxt_acq_cnt = fll_in_band ? acq_cnt_ff + 16'h1 : 16'h0;
				if (acq_cnt_ff >= 16'(ACQ_CYCLES - 1) && fll_in_band)
					nxt_lock = fcm_pkg::ST_LOCK;
			end
			fcm_pkg::ST_LOCK:
			begin
				if (fll_out_of_tol)
					nxt_lock = fcm_pkg::ST_LOST;
			end
			fcm_pkg::ST_LOST:
			begin
				nxt_acq_cnt = 16'h0;
				nxt_lock = fcm_pkg::ST_ACQ;
			end
			default:
				nxt_lock = fcm_pkg::ST_OFF;
		endcase
		if (!fll_on)
			nxt_lock = fcm_pkg::ST_OFF;
		else if (relock)
		begin
			nxt_lock = fcm_pkg::ST_ACQ;
			nxt_acq_cnt = 16'h0;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lock_ff <= fcm_pkg::ST_OFF;
			acq_cnt_ff <= 16'h0;
		end
		else
		begin
			lock_ff <= nxt_lock;
			acq_cnt_ff <= nxt_acq_cnt;
		end
	end

	fcm_sync #(
		.W(3)
	) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d({ref_int_ff, src_ff}),
		.q(sync_q)
	);

	assign out_clock_source = src_ff;
	assign fll_enable = fll_on;
	assign fll_multiplier = 16'(fcm_pkg::FLL_MULT);
	assign ext_ref_enable = !ctrl_ff.ref_select_internal ||
		clksel == fcm_pkg::CLK_EXT;
	assign int_ref_enable = ctrl_ff.ref_select_internal ||
		ctrl_ff.internal_ref_out_enable;
	assign out_clock_gate = !stop_ff;
	assign int_ref_clock_gate = ctrl_ff.internal_ref_out_enable &&
		(!stop_ff || ctrl_ff.internal_ref_stop_enable);
	assign osc_reset_freq = stop_entry;
	assign reset_req = cme_ff && ext_clock_lost;

	a_lost_irq: assert property (@(posedge sys_clk) disable iff (!rstn)
		lost_lock_irq == (lost_ff && lost_lock_irq_enable_ff)) else $error("irq mismatch");
	a_lost_set: assert property (@(posedge sys_clk) disable iff (!rstn)
		lose |=> lost_ff) else $error("lost flag not set");
	a_lost_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_sts && !wb_dat_i[7] && !lose |=> $stable(lost_ff))
		else $error("zero write changed flag");
	a_relock_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
		relock |=> status[6] == 1'b0) else $error("lock kept");
	a_stop_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
		stop_ff |-> status[6] == 1'b0) else $error("lock in stop");
	a_status_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		status[5] == 1'b0 && status[1:0] == 2'h0)
		else $error("reserved bit set");
	a_mode_lag: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(src_ff) |-> ##2 sync_q[1:0] == $past(src_ff, 2))
		else $error("mode status lag");
	a_pd_unlock: assert property (@(posedge sys_clk) disable iff (!rstn)
		fll_pd |=> lock_ff == fcm_pkg::ST_OFF) else $error("lock while off");
endmodule

// file: testbench/testbench.sv
// Self-checking testbench of the clock mode and status block.
`define CHK(nm, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
		end \
	end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int ACQ = 16;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic wb_cyc = 1'h0;
	logic wb_stb = 1'h0;
	logic wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_dat = 32'h0;
	logic stop_req = 1'h0;
	logic debug_active = 1'h0;
	logic int_ready = 1'h1;
	logic ext_ready = 1'h1;
	logic ext_lost = 1'h0;
	logic in_band = 1'h0;
	logic out_tol = 1'h0;
	logic [31:0] wb_rdat;
	logic [31:0] d;
	logic [15:0] mult;
	logic [1:0] src;
	logic wb_ack, wb_err, e, fll_en, ext_en, int_en, int_gate, out_gate;
	logic osc_rst, irq, rst_req;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	int n_osc = 0;
	int k;
	fcm_top #(.ACQ_CYCLES(ACQ)) i_fcm_top (.sys_clk(sys_clk), .rstn(rstn),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
		.stop_req(stop_req), .debug_active(debug_active),
		.int_ref_ready(int_ready), .ext_ref_ready(ext_ready),
		.ext_clock_lost(ext_lost), .fll_in_band(in_band),
		.fll_out_of_tol(out_tol), .out_clock_source(src),
		.fll_enable(fll_en), .ext_ref_enable(ext_en),
		.int_ref_enable(int_en), .int_ref_clock_gate(int_gate),
		.out_clock_gate(out_gate), .osc_reset_freq(osc_rst),
		.fll_multiplier(mult), .lost_lock_irq(irq), .reset_req(rst_req));
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (osc_rst === 1'h1)
			n_osc++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compared %0d, mismatched %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_cy(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Holds the request until ack or err is sampled high at a rising edge.
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		@(posedge sys_clk);
		while (wb_ack !== 1'h1 && wb_err !== 1'h1 && n < 50)
		begin
			n++;
			@(posedge sys_clk);
		end
		if (n >= 50)
			n_mismatch++;
		d = wb_rdat;
		e = wb_err;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		wb_we <= 1'h0;
	endtask
	task automatic rd_sts();
		wait_cy(3);
		wb(1'h0, fcm_pkg::ADDR_STATUS, 32'h0);
	endtask
	task automatic t_reset();
		wb(1'h0, fcm_pkg::ADDR_CTRL, 32'h0);
		`CHK("ctrl", 9'h004, d[8:0])
		rd_sts();
		`CHK("status", 8'h10, d[7:0])
		`CHK("mult", 16'h0500, mult)
		wb(1'h1, fcm_pkg::ADDR_STATUS, 32'h20);
		rd_sts();
		`CHK("bit5", 1'h0, d[5])
		wb(1'h0, 8'h10, 32'h0);
		`CHK("err", 1'h1, e)
		$display("test reset done");
	endtask
	task automatic t_lock();
		in_band <= 1'h1;
		wait_cy(ACQ + 4);
		rd_sts();
		`CHK("locked", 1'h1, d[6])
		wb(1'h1, fcm_pkg::ADDR_TRIM, 32'h81);
		rd_sts();
		`CHK("trim unlock", 1'h0, d[6])
		wait_cy(ACQ + 4);
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h00c);
		rd_sts();
		`CHK("div unlock", 1'h0, d[6])
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h004);
		wait_cy(ACQ + 4);
		$display("test lock done");
	endtask
	task automatic t_lost();
		out_tol <= 1'h1;
		wait_cy(2);
		out_tol <= 1'h0;
		rd_sts();
		`CHK("lost", 1'h1, d[7])
		`CHK("irq off", 1'h0, irq)
		wb(1'h1, fcm_pkg::ADDR_IRQCTL, 32'h80);
		wait_cy(2);
		`CHK("irq on", 1'h1, irq)
		wb(1'h1, fcm_pkg::ADDR_STATUS, 32'h00);
		rd_sts();
		`CHK("w0 keeps", 1'h1, d[7])
		wb(1'h1, fcm_pkg::ADDR_STATUS, 32'h80);
		rd_sts();
		`CHK("w1 clears", 1'h0, d[7])
		`CHK("irq clr", 1'h0, irq)
		$display("test lost done");
	endtask
	task automatic t_modes();
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h044);
		rd_sts();
		`CHK("int byp", 3'h5, d[4:2])
		`CHK("src int", 2'h1, src)
		`CHK("fll on", 1'h1, fll_en)
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h144);
		rd_sts();
		`CHK("fll lp", 1'h0, fll_en)
		`CHK("no lock", 1'h0, d[6])
		debug_active <= 1'h1;
		wait_cy(2);
		`CHK("fll dbg", 1'h1, fll_en)
		debug_active <= 1'h0;
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h080);
		rd_sts();
		`CHK("ext byp", 3'h2, d[4:2])
		`CHK("src ext", 2'h2, src)
		`CHK("fll ext", 1'h1, fll_en)
		`CHK("int off", 1'h0, int_en)
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h180);
		wait_cy(3);
		`CHK("fll elp", 1'h0, fll_en)
		`CHK("ext on", 1'h1, ext_en)
		int_ready <= 1'h0;
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h044);
		wait_cy(4);
		`CHK("keep ext", 2'h2, src)
		int_ready <= 1'h1;
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h000);
		wait_cy(4);
		`CHK("fee src", 2'h0, src)
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h007);
		wait_cy(ACQ + 4);
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h005);
		rd_sts();
		`CHK("irout keeps lock", 1'h1, d[6])
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h007);
		$display("test modes done");
	endtask
	task automatic t_stop();
		k = n_osc;
		stop_req <= 1'h1;
		rd_sts();
		`CHK("stop lock", 1'h0, d[6])
		`CHK("out gate", 1'h0, out_gate)
		`CHK("ir gate", 1'h1, int_gate)
		`CHK("osc pulse", 1, n_osc - k)
		stop_req <= 1'h0;
		rd_sts();
		`CHK("relock", 1'h0, d[6])
		wb(1'h1, fcm_pkg::ADDR_CTRL, 32'h006);
		stop_req <= 1'h1;
		wait_cy(3);
		`CHK("ir static", 1'h0, int_gate)
		stop_req <= 1'h0;
		$display("test stop done");
	endtask
	task automatic t_mon();
		wb(1'h1, fcm_pkg::ADDR_IRQCTL, 32'h20);
		ext_lost <= 1'h1;
		wait_cy(2);
		`CHK("rst req", 1'h1, rst_req)
		wb(1'h1, fcm_pkg::ADDR_IRQCTL, 32'h00);
		wait_cy(2);
		`CHK("rst off", 1'h0, rst_req)
		$display("test monitor done");
	endtask
	initial
	begin
		wait_cy(2);
		rstn <= 1'h1;
		t_reset();
		t_lock();
		t_lost();
		t_modes();
		t_stop();
		t_mon();
		print_verdict();
	end
endmodule
